// >>> logic/mdc_pkg.sv
// Behaviour
// - Valid selector routes peripheral TX request to even, RX to odd channel.
// - Equal selector values: the lower selector field owns the routing.
// - Channel-on bit clears itself when the channel's transfer completes.
// - Request mode 0: memory-to-memory, starts as soon as channel-on is set.
// - Request mode 1: cycles start only on the routed peripheral request.
// - Requests level-sensitive by default; sense bit selects rising-edge start.
// - Data moves source to destination for the length, 8/16/32-bit width.
// - 16-bit index cleared at start, compared with length after each item.
// - Address is start plus index times increment flag times bus width.
// - Continue while start condition holds; stop when index equals length.
// - At stop clear channel-on unless request mode 1 with wraparound.
// - Peripheral channel waits after each item until request shows ready.
// - Wraparound restarts index at zero; request mode 0 always stops.
// - Interrupt when index equals interrupt count, before index increments.
// - Three-bit priority picks the channel; ties go to a running mem-to-mem channel, else to the lower channel number.
// - Memory-to-memory channel with idle bit and no memory-init bit is preempted by higher priority.
// - Memory-init bit locks the bus to a memory-to-memory channel until it completes.
// - Freeze-set write suspends all channels; freeze-reset write resumes.
// - Freeze also pauses memory-to-memory transfers mid-transfer.
// - Key protection turns channel 5 into a fixed key-to-cipher mover.
// - Burst mode marks accesses as four- or eight-beat incrementing bursts.
// - Six independent channels share the multiplexed peripheral requests.
package mdc_pkg;
  localparam int NCH   = 6;
  localparam int NPER  = 8;
  localparam int SELW  = 4;
  // Register map, byte addresses; channel block stride 0x20
  localparam logic [9:0] OFS_SRC     = 10'h000;
  localparam logic [9:0] OFS_DST     = 10'h004;
  localparam logic [9:0] OFS_LEN     = 10'h008;
  localparam logic [9:0] OFS_ICNT    = 10'h00c;
  localparam logic [9:0] OFS_CTRL    = 10'h010;
  localparam logic [9:0] OFS_IDX     = 10'h014;
  localparam logic [9:0] OFS_MUX     = 10'h100;
  localparam logic [9:0] OFS_FRZ_SET = 10'h104;
  localparam logic [9:0] OFS_FRZ_RST = 10'h108;
  localparam logic [9:0] OFS_FRZ_STS = 10'h10c;
  // Control field positions
  localparam int CB_ON    = 0;
  localparam int CB_BW    = 1;   // 2 bits: 0 byte, 1 half, 2 word
  localparam int CB_SINC  = 3;
  localparam int CB_DINC  = 4;
  localparam int CB_RMODE = 5;
  localparam int CB_WRAP  = 6;
  localparam int CB_PRIO  = 7;   // 3 bits
  localparam int CB_IDLE  = 10;
  localparam int CB_INIT  = 11;
  localparam int CB_SENSE = 12;
  localparam int CB_BURST = 13;  // 2 bits: 0 off, 1 four-beat, 2 eight-beat
  localparam logic [11:0] MUX_RESET = 12'hfff;
  localparam logic [15:0] IDX_RESET = 16'h0000;
  typedef enum logic [3:0] {
    ST_ARB   = 4'b0001,
    ST_READ  = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_STEP  = 4'b1000
  } mdc_state_e;
endpackage : mdc_pkg

// >>> logic/mdc_dma.sv
`timescale 1ns/1ns
`default_nettype none
module mdc_dma
  import mdc_pkg::*;
#(
  parameter logic [31:0] KEY_AREA_BASE = 32'h0000_0000,
  parameter logic [31:0] CIPHER_KEY_PORT = 32'h0000_0100
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Register port
  input  wire logic [9:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Peripheral request pins and acknowledges
  input  wire logic [NPER-1:0]   periph_tx_req,
  input  wire logic [NPER-1:0]   periph_rx_req,
  output logic      [NPER-1:0]   periph_tx_ack,
  output logic      [NPER-1:0]   periph_rx_ack,
  // Configuration strap
  input  wire logic              key_protection_option,
  // Memory master
  output logic                   mem_req,
  output logic                   mem_write,
  output logic      [31:0]       mem_addr,
  output logic      [1:0]        mem_size,
  output logic      [1:0]        mem_burst,
  output logic                   mem_lock,
  output logic      [31:0]       mem_wdata,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_ready,
  // Channel events
  output logic      [NCH-1:0]    chan_irq
);

  function automatic logic [31:0] addr_calc(input logic [31:0] start,
                                            input logic [15:0] idx,
                                            input logic        inc,
                                            input logic [1:0]  bw);
    logic [31:0] step;
    step = {16'h0000, idx} << bw;
    addr_calc = inc ? start + step : start;
  endfunction : addr_calc

  // Per-channel configuration
  logic [31:0] src_start [NCH];
  logic [31:0] dst_start [NCH];
  logic [15:0] xfer_len  [NCH];
  logic [15:0] int_cnt   [NCH];
  logic [15:0] xfer_idx  [NCH];
  logic [1:0]  bus_width [NCH];
  logic [2:0]  chan_prio [NCH];
  logic [1:0]  burst_sel [NCH];
  logic [NCH-1:0] chan_on, src_inc, dst_inc, req_trigger_mode;
  logic [NCH-1:0] wraparound_mode, idle_ok, mem_init, req_sense;
  logic [11:0] request_multiplexer;
  logic        freeze_channels;
  logic        key_s1, key_prot;

  // Engine
  mdc_state_e  state;
  logic [2:0]  cur;
  logic [31:0] data_q;
  logic [NCH-1:0] chan_ack;

  // Register decode
  logic [2:0] wr_ch;
  logic [9:0] wr_ofs;
  logic       wr_chan;
  assign wr_ch   = reg_addr[7:5];
  assign wr_ofs  = {5'h00, reg_addr[4:0]};
  assign wr_chan = ~reg_addr[8] && (wr_ch < 3'(NCH));

  // Peripheral pins cross into the clock domain through two flops
  logic [NPER-1:0] tx_s1, tx_s2, rx_s1, rx_s2;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_s1 <= '0;
      tx_s2 <= '0;
      rx_s1 <= '0;
      rx_s2 <= '0;
    end else begin
      tx_s1 <= periph_tx_req;
      tx_s2 <= tx_s1;
      rx_s1 <= periph_rx_req;
      rx_s2 <= rx_s1;
    end
  end

  // Strap is synchronised, then held as a level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      key_s1   <= 1'b0;
      key_prot <= 1'b0;
    end else begin
      key_s1   <= key_protection_option;
      key_prot <= key_s1;
    end
  end

  // Request routing: selector k feeds channels 2k (TX) and 2k+1 (RX)
  logic [NCH-1:0] route_ok, chan_req, chan_req_d, edge_pend;
  logic [SELW-1:0] sel_of [NCH];
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      sel_of[c]   = request_multiplexer[(c/2)*SELW +: SELW];
      route_ok[c] = sel_of[c] < SELW'(NPER);
      for (int k = 0; k < c/2; k++)
        if (request_multiplexer[k*SELW +: SELW] == sel_of[c])
          route_ok[c] = 1'b0;
      chan_req[c] = 1'b0;
      if (route_ok[c])
        chan_req[c] = (c % 2 == 0) ? tx_s2[sel_of[c][2:0]]
                                   : rx_s2[sel_of[c][2:0]];
    end
  end

  // Acknowledges go back along the same route
  always_comb begin
    periph_tx_ack = '0;
    periph_rx_ack = '0;
    for (int c = 0; c < NCH; c++)
      if (route_ok[c] && chan_ack[c]) begin
        if (c % 2 == 0) periph_tx_ack[sel_of[c][2:0]] = 1'b1;
        else            periph_rx_ack[sel_of[c][2:0]] = 1'b1;
      end
  end

  // Arbitration result, declared early for the edge consumer
  logic [2:0] win;
  logic       win_ok, hold_cur;

  // Edge detection; a new edge wins over the consuming clear
  logic take;
  assign take = (state == ST_ARB) && !freeze_channels;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chan_req_d <= '0;
      edge_pend  <= '0;
    end else begin
      chan_req_d <= chan_req;
      for (int c = 0; c < NCH; c++)
        edge_pend[c] <= (chan_req[c] && !chan_req_d[c])
                     || (edge_pend[c] && !(take && win_ok
                                           && win == 3'(c)));
    end
  end

  // Start condition per channel
  logic [NCH-1:0] want;
  always_comb begin
    for (int c = 0; c < NCH; c++)
      if (!req_trigger_mode[c])
        want[c] = chan_on[c];
      else
        want[c] = chan_on[c] && (req_sense[c] ? edge_pend[c]
                                              : chan_req[c]);
  end

  // Arbitration; a running mem-to-mem channel yields only upward
  logic [2:0] best_prio;
  assign hold_cur = chan_on[cur] && !req_trigger_mode[cur]
                 && (mem_init[cur] || !idle_ok[cur]);
  always_comb begin
    win       = cur;
    win_ok    = 1'b0;
    best_prio = 3'h0;
    if (want[cur] && !req_trigger_mode[cur]) begin
      win_ok    = 1'b1;
      best_prio = chan_prio[cur];
    end
    if (!hold_cur)
      for (int c = 0; c < NCH; c++)
        if (want[c] && (!win_ok || chan_prio[c] > best_prio)) begin
          win       = 3'(c);
          win_ok    = 1'b1;
          best_prio = chan_prio[c];
        end
  end

  // Freeze control
  always_ff @(posedge ref_clk) begin
    if (reset)
      freeze_channels <= 1'b0;
    else if (reg_wr && reg_addr == OFS_FRZ_SET && reg_wdata[0])
      freeze_channels <= 1'b1;
    else if (reg_wr && reg_addr == OFS_FRZ_RST && reg_wdata[0])
      freeze_channels <= 1'b0;
  end

  // Static configuration registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      request_multiplexer <= MUX_RESET;
      for (int c = 0; c < NCH; c++) begin
        src_start[c] <= '0;
        dst_start[c] <= '0;
        xfer_len[c]  <= '0;
        int_cnt[c]   <= '0;
        bus_width[c] <= '0;
        chan_prio[c] <= '0;
        burst_sel[c] <= '0;
      end
      src_inc <= '0; dst_inc <= '0; req_trigger_mode <= '0;
      wraparound_mode <= '0; idle_ok <= '0; mem_init <= '0;
      req_sense <= '0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_MUX)
        request_multiplexer <= reg_wdata[11:0];
      if (wr_chan) begin
        case (wr_ofs)
          OFS_SRC:  src_start[wr_ch] <= reg_wdata;
          OFS_DST:  dst_start[wr_ch] <= reg_wdata;
          OFS_LEN:  xfer_len[wr_ch]  <= reg_wdata[15:0];
          OFS_ICNT: int_cnt[wr_ch]   <= reg_wdata[15:0];
          OFS_CTRL: begin
            bus_width[wr_ch]        <= reg_wdata[CB_BW +: 2];
            src_inc[wr_ch]          <= reg_wdata[CB_SINC];
            dst_inc[wr_ch]          <= reg_wdata[CB_DINC];
            req_trigger_mode[wr_ch] <= reg_wdata[CB_RMODE];
            wraparound_mode[wr_ch]  <= reg_wdata[CB_WRAP];
            chan_prio[wr_ch]        <= reg_wdata[CB_PRIO +: 3];
            idle_ok[wr_ch]          <= reg_wdata[CB_IDLE];
            mem_init[wr_ch]         <= reg_wdata[CB_INIT];
            req_sense[wr_ch]        <= reg_wdata[CB_SENSE];
            burst_sel[wr_ch]        <= reg_wdata[CB_BURST +: 2];
          end
          default: ;
        endcase
      end
    end
  end

  // Effective addresses; the secure channel ignores software pointers
  logic [31:0] eff_src, eff_dst;
  logic        sec_cur;
  assign sec_cur = key_prot && (win == 3'd5);
  assign eff_src = sec_cur ? KEY_AREA_BASE : src_start[win];
  assign eff_dst = sec_cur ? CIPHER_KEY_PORT : dst_start[win];

  // Stop decision at the end of an item
  logic at_len, stop_off;
  assign at_len   = xfer_idx[cur] == xfer_len[cur];
  assign stop_off = !req_trigger_mode[cur]
                 || !wraparound_mode[cur];

  // Channel-on and index: software start, hardware completion
  logic ctrl_wr_on;
  assign ctrl_wr_on = reg_wr && wr_chan && wr_ofs == OFS_CTRL;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chan_on <= '0;
      for (int c = 0; c < NCH; c++)
        xfer_idx[c] <= IDX_RESET;
    end else begin
      if (state == ST_STEP) begin
        if (!at_len)
          xfer_idx[cur] <= xfer_idx[cur] + 16'h0001;
        else if (stop_off)
          chan_on[cur] <= 1'b0;
        else
          xfer_idx[cur] <= IDX_RESET;
      end
      if (ctrl_wr_on) begin
        chan_on[wr_ch] <= reg_wdata[CB_ON];
        if (reg_wdata[CB_ON] && !chan_on[wr_ch])
          xfer_idx[wr_ch] <= IDX_RESET;
      end
    end
  end

  // Secure flag of the channel that owns the engine
  logic sec_cur_q;

  // Transfer engine: read one item, write it, then step the index
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state     <= ST_ARB;
      cur       <= '0;
      mem_write <= 1'b0;
      mem_addr  <= '0;
      mem_size  <= '0;
      mem_burst <= '0;
      mem_lock  <= 1'b0;
      mem_wdata <= '0;
      data_q    <= '0;
    end else begin
      case (state)
        ST_ARB: begin
          mem_lock <= hold_cur && mem_init[cur] && chan_on[cur];
          if (take && win_ok) begin
            cur       <= win;
            mem_write <= 1'b0;
            mem_addr  <= addr_calc(eff_src, xfer_idx[win],
                                   src_inc[win], bus_width[win]);
            mem_size  <= bus_width[win];
            mem_burst <= burst_sel[win];
            mem_lock  <= mem_init[win];
            state     <= ST_READ;
          end
        end
        ST_READ:
          if (mem_req && mem_ready) begin
            data_q    <= mem_rdata;
            mem_wdata <= mem_rdata;
            mem_write <= 1'b1;
            mem_addr  <= addr_calc(sec_cur_q ? CIPHER_KEY_PORT
                                             : dst_start[cur],
                                   xfer_idx[cur], dst_inc[cur],
                                   bus_width[cur]);
            state     <= ST_WRITE;
          end
        ST_WRITE:
          if (mem_req && mem_ready) begin
            mem_write <= 1'b0;
            state     <= ST_STEP;
          end
        ST_STEP:
          state <= ST_ARB;
        default:
          state <= ST_ARB;
      endcase
    end
  end

  assign sec_cur_q = key_prot && (cur == 3'd5);

  // Frozen engine stops issuing accesses, even mid-item
  assign mem_req = (state == ST_READ || state == ST_WRITE)
                && !freeze_channels;

  // Item completion events: interrupt before increment, peripheral ack
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chan_irq <= '0;
      chan_ack <= '0;
    end else begin
      chan_irq <= '0;
      chan_ack <= '0;
      if (state == ST_STEP) begin
        chan_irq[cur] <= xfer_idx[cur] == int_cnt[cur];
        chan_ack[cur] <= req_trigger_mode[cur];
      end
    end
  end

  // Read port: data stand in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset)
      reg_rdata <= '0;
    else if (reg_rd) begin
      reg_rdata <= '0;
      if (wr_chan)
        case (wr_ofs)
          OFS_SRC:  reg_rdata <= src_start[wr_ch];
          OFS_DST:  reg_rdata <= dst_start[wr_ch];
          OFS_LEN:  reg_rdata <= {16'h0000, xfer_len[wr_ch]};
          OFS_ICNT: reg_rdata <= {16'h0000, int_cnt[wr_ch]};
          OFS_IDX:  reg_rdata <= {16'h0000, xfer_idx[wr_ch]};
          OFS_CTRL: reg_rdata <= {17'h00000, burst_sel[wr_ch],
                       req_sense[wr_ch], mem_init[wr_ch], idle_ok[wr_ch],
                       chan_prio[wr_ch], wraparound_mode[wr_ch],
                       req_trigger_mode[wr_ch], dst_inc[wr_ch],
                       src_inc[wr_ch], bus_width[wr_ch], chan_on[wr_ch]};
          default:  reg_rdata <= '0;
        endcase
      else if (reg_addr == OFS_MUX)
        reg_rdata <= {20'h00000, request_multiplexer};
      else if (reg_addr == OFS_FRZ_STS)
        reg_rdata <= {31'h00000000, freeze_channels};
    end
  end

  // Checks
  logic step_q;
  logic [2:0] cur_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      step_q <= 1'b0;
      cur_q  <= '0;
    end else begin
      step_q <= state == ST_STEP;
      cur_q  <= cur;
    end
  end

  AST_ON_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
    (state == ST_STEP && at_len && stop_off && !ctrl_wr_on)
    |=> !chan_on[cur_q])
    else $error("channel stayed on after its final item");
  AST_WRAP: assert property (@(posedge ref_clk) disable iff (reset)
    (state == ST_STEP && at_len && !stop_off && !ctrl_wr_on)
    |=> chan_on[cur_q] && xfer_idx[cur_q] == 16'h0000)
    else $error("wraparound did not restart the index");
  AST_IDX_INC: assert property (@(posedge ref_clk) disable iff (reset)
    (state == ST_STEP && !at_len && !ctrl_wr_on)
    |=> xfer_idx[cur_q] == $past(xfer_idx[cur]) + 16'h0001)
    else $error("index did not advance by one");
  AST_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
    step_q |-> chan_irq[cur_q] ==
      ($past(xfer_idx[cur]) == $past(int_cnt[cur])))
    else $error("interrupt does not match the interrupt count");
  AST_FREEZE: assert property (@(posedge ref_clk) disable iff (reset)
    freeze_channels |-> !mem_req)
    else $error("access issued while frozen");
  AST_READ_ADDR: assert property (@(posedge ref_clk) disable iff (reset)
    (state == ST_READ && !sec_cur_q) |-> mem_addr ==
      addr_calc(src_start[cur], xfer_idx[cur], src_inc[cur], bus_width[cur]))
    else $error("source address formed wrongly");
  AST_LOCK: assert property (@(posedge ref_clk) disable iff (reset)
    (take && hold_cur && mem_init[cur] && want[cur])
    |=> cur == $past(cur) && state == ST_READ)
    else $error("locked channel lost the bus");
  AST_ROUTE_TIE: assert property (@(posedge ref_clk) disable iff (reset)
    (request_multiplexer[3:0] == request_multiplexer[7:4]) |-> !route_ok[2])
    else $error("duplicate selector was routed");
  AST_PERIPH_GATE: assert property (@(posedge ref_clk) disable iff (reset)
    (take && win_ok && req_trigger_mode[win] && !req_sense[win])
    |-> chan_req[win])
    else $error("peripheral channel started without a request");

  COV_M2M_DONE: cover property (@(posedge ref_clk)
    state == ST_STEP && at_len && !req_trigger_mode[cur]);
  COV_WRAP: cover property (@(posedge ref_clk)
    state == ST_STEP && at_len && !stop_off);
  COV_FREEZE_MID: cover property (@(posedge ref_clk)
    state == ST_READ && freeze_channels);
  COV_PREEMPT: cover property (@(posedge ref_clk)
    take && win_ok && win != cur && chan_on[cur] && idle_ok[cur]);

endmodule : mdc_dma
`default_nettype wire

// >>> bench/mdc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mdc_mem_model (
  // Clock and stall control
  input  wire logic        ref_clk,
  input  wire logic        slow,
  // Master side
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ready
);
  logic [31:0] mem [64];
  logic [31:0] last;
  logic        tick;
  // Known pattern so that copies can be predicted
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'ha500_0000 | 32'(i);
    end
    last = 32'h0000_0000;
    tick = 1'b0;
  end
  // Slow mode stalls every other cycle
  always @(posedge ref_clk) begin
    tick <= ~tick;
    if (mem_req && mem_ready && mem_write) mem[mem_addr[7:2]] <= mem_wdata;
    if (mem_req && mem_ready && !mem_write) last <= mem_rdata;
  end
  assign mem_ready = !slow || tick;
  // Idle bus shows the inverse of the last read, never a stale match
  assign mem_rdata = (mem_req && !mem_write) ? mem[mem_addr[7:2]] : ~last;
endmodule : mdc_mem_model
`default_nettype wire

// >>> bench/tb_mdc_dma.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t mismatch %h vs %h", $time, g, e); end end
module tb_mdc_dma;
  import mdc_pkg::*;
  logic        ref_clk, reset, reg_wr, reg_rd, mem_req, mem_write;
  logic        mem_lock, mem_ready, slow;
  logic [9:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, d, e;
  logic [1:0]  mem_size, mem_burst;
  logic [7:0]  tx_req, rx_req, tx_ack, rx_ack;
  logic [5:0]  chan_irq;
  int          fail_count, checks, irq_n, ack_n, bad_ack;
  localparam logic [31:0] WORD = 32'(2 << CB_BW) | 32'(1 << CB_ON);
  localparam logic [31:0] INC  = 32'(1 << CB_SINC) | 32'(1 << CB_DINC);

  mdc_dma u_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .periph_tx_req(tx_req), .periph_rx_req(rx_req),
    .periph_tx_ack(tx_ack), .periph_rx_ack(rx_ack),
    .key_protection_option(1'b0), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_size(mem_size),
    .mem_burst(mem_burst), .mem_lock(mem_lock), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready), .chan_irq(chan_irq));
  mdc_mem_model u_mem (.ref_clk(ref_clk), .slow(slow), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready));

  // Clock, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Event counters for interrupts and acknowledges
  always @(posedge ref_clk) begin
    if (chan_irq[0] === 1'b1) irq_n++;
    if (tx_ack[2] === 1'b1) ack_n++;
    if ((tx_ack & 8'hfb) !== 8'h00 || rx_ack !== 8'h00) bad_ack++;
  end

  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stands from the cycle after the strobe until the next read
  task automatic rd(input logic [9:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // Bounded poll on the channel-on bit of channel 0
  task automatic wait_off();
    for (int i = 0; i < 300; i++) begin
      rd(OFS_CTRL, d);
      if (d[CB_ON] === 1'b0) return;
    end
    fail_count++;
    $display("[ERR] %0t channel never finished", $time);
  endtask : wait_off
  // Program channel 0 and start it with the given control word
  task automatic run(input logic [31:0] s, dst, n, ic, ctl);
    wr(OFS_SRC, s);
    wr(OFS_DST, dst);
    wr(OFS_LEN, n);
    wr(OFS_ICNT, ic);
    irq_n = 0;
    wr(OFS_CTRL, ctl);
  endtask : run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 10'h000;
    reg_wdata = 32'h0; tx_req = 8'h00; rx_req = 8'h00; slow = 1'b0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    // Reset values and an unmapped read
    rd(OFS_MUX, d); `CHK(d[11:0], MUX_RESET)
    rd(OFS_IDX, d); `CHK(d[15:0], IDX_RESET)
    rd(10'h3fc, d); `CHK(d, 32'h0)
    $display("test reset done");
    // Incrementing word copy, four items, interrupt at index 1
    run(32'h0, 32'h80, 32'd3, 32'd1, WORD | INC);
    wait_off();
    for (int k = 0; k < 4; k++) begin
      `CHK(u_mem.mem[32 + k], 32'ha500_0000 | 32'(k))
    end
    rd(OFS_IDX, d); `CHK(d[15:0], 16'd3)
    `CHK(irq_n, 1)
    $display("test copy done");
    // Locked fill from a fixed source through a stalling memory
    slow = 1'b1;
    run(32'h10, 32'he0, 32'd2, 32'd0, WORD | 32'(1 << CB_DINC)
        | 32'(1 << CB_INIT));
    wait_off();
    for (int k = 0; k < 3; k++) begin
      `CHK(u_mem.mem[56 + k], 32'ha500_0004)
    end
    `CHK(irq_n, 1)
    slow = 1'b0;
    $display("test fill done");
    // Freeze in the middle of a copy, then resume
    run(32'h40, 32'ha0, 32'd7, 32'd9, WORD | INC);
    wr(OFS_FRZ_SET, 32'h1);
    repeat (3) @(posedge ref_clk);
    rd(OFS_IDX, d);
    repeat (20) @(posedge ref_clk);
    #1 `CHK(mem_req, 1'b0)
    rd(OFS_FRZ_STS, e); `CHK(e[0], 1'b1)
    rd(OFS_IDX, e); `CHK(e, d)
    rd(OFS_CTRL, d); `CHK(d[CB_ON], 1'b1)
    wr(OFS_FRZ_RST, 32'h1);
    wait_off();
    `CHK(u_mem.mem[47], 32'ha500_0017)
    `CHK(irq_n, 0)
    $display("test freeze done");
    // Peripheral request on selector 2 drives channel 0
    ack_n = 0;
    bad_ack = 0;
    wr(OFS_MUX, 32'hff2);
    run(32'h14, 32'h60, 32'd1, 32'd0, WORD | 32'(1 << CB_DINC)
        | 32'(1 << CB_RMODE));
    repeat (20) @(posedge ref_clk);
    rd(OFS_IDX, d); `CHK(d[15:0], 16'd0)
    `CHK(ack_n, 0)
    @(posedge ref_clk);
    tx_req <= 8'h04;
    wait_off();
    @(posedge ref_clk);
    tx_req <= 8'h00;
    `CHK(ack_n, 2)
    `CHK(bad_ack, 0)
    `CHK(u_mem.mem[25], 32'ha500_0005)
    $display("test peripheral done");
    report_and_stop();
  end
endmodule : tb_mdc_dma
`default_nettype wire
